// *** design/multi_press_detector.sv ***
/*
 * Eight-input multiple-press detector. Each input counts presses inside
 * a gap time and queues one-bit object telegrams onto a shared sender.
 * Assumes telegrams are accepted on tx_valid_o and tx_ready_i both high,
 * and received object writes arrive as single-cycle rx_valid_i pulses.
 */
`timescale 1ns/1ps
`default_nettype none
module multi_press_detector #(
    parameter int N           = mpd_pkg::NUM_INPUTS,
    parameter int TICK_CYCLES = mpd_pkg::TICK_CYCLES
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [N-1:0] contact_i,
    input  wire logic [N-1:0] manual_mode_i,
    input  wire logic [N-1:0] manual_level_i,
    input  wire logic [N-1:0] pol_open_i,
    input  wire logic [N-1:0] send_each_i,
    input  wire logic [N-1:0] long_en_i,
    input  wire logic [N-1:0] block_en_i,
    input  wire logic [2*N-1:0] max_fold_i,
    input  wire logic [2*N-1:0] fold_sel_i,
    input  wire logic [2*N-1:0] long_sel_i,
    input  wire logic [3*N-1:0] deb_sel_i,
    input  wire logic [14*N-1:0] gap_ms_i,
    input  wire logic [14*N-1:0] long_ms_i,
    input  wire logic         rx_valid_i,
    input  wire logic [6:0]   rx_obj_i,
    input  wire logic         rx_val_i,
    output logic              tx_valid_o,
    input  wire logic         tx_ready_i,
    output logic [6:0]        tx_obj_o,
    output logic              tx_val_o,
    output logic [N-1:0]      blocked_o
);

    typedef enum logic [3:0] {
        S_IDLE  = 4'b0001,
        S_PRESS = 4'b0010,
        S_GAP   = 4'b0100,
        S_LONG  = 4'b1000
    } press_state_t;

    // ************************************************************
    // Millisecond tick
    // ************************************************************
    logic [31:0] tick_cnt_q;
    logic        tick_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt_q <= 32'h0;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= 32'h0;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
            tick_q     <= 1'b0;
        end
    end

    function automatic logic sent_value(input logic [1:0] sel, input logic stored);
        logic v;
        v = 1'b0;
        if (sel == mpd_pkg::SEND_ON) begin
            v = 1'b1;
        end else if (sel == mpd_pkg::SEND_TOGGLE) begin
            v = ~stored;
        end
        return v;
    endfunction : sent_value

    function automatic logic [13:0] clamp_ms(input logic [13:0] ms);
        logic [13:0] r;
        r = ms;
        if (ms < mpd_pkg::TIME_MIN_MS) begin
            r = mpd_pkg::TIME_MIN_MS;
        end else if (ms > mpd_pkg::TIME_MAX_MS) begin
            r = mpd_pkg::TIME_MAX_MS;
        end
        return r;
    endfunction : clamp_ms

    // ************************************************************
    // Telegram sender
    // ************************************************************
    logic [N-1:0] pend_q;
    logic [N-1:0] grant;
    logic [2:0]   pend_ofs_q [N];
    logic         pend_val_q [N];
    logic         load;
    logic [6:0]   sel_obj;
    logic         sel_val;

    assign load = ~tx_valid_o | tx_ready_i;

    always_comb begin
        grant   = '0;
        sel_obj = 7'h0;
        sel_val = 1'b0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
                grant   = '0;
                grant[i] = load;
                sel_obj = 7'(mpd_pkg::OBJ_BASE + i * mpd_pkg::OBJ_STEP)
                          + {4'h0, pend_ofs_q[i]};
                sel_val = pend_val_q[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_valid_o <= 1'b0;
            tx_obj_o   <= 7'h0;
            tx_val_o   <= 1'b0;
        end else if (load) begin
            tx_valid_o <= |pend_q;
            tx_obj_o   <= sel_obj;
            tx_val_o   <= sel_val;
        end
    end

    // ************************************************************
    // Per-input press logic
    // ************************************************************
    for (genvar c = 0; c < N; c++) begin : g_ch
        logic         filt_level;
        logic         src_level;
        logic         eff_q;
        logic         block_q;
        logic         blocked;
        logic         edge_now;
        logic         pressed;
        logic         press_edge;
        logic         rel_edge;
        press_state_t st_q;
        press_state_t st_d;
        logic [2:0]   cnt_q;
        logic [2:0]   cnt_d;
        logic [2:0]   max_cnt;
        logic [13:0]  tmr_q;
        logic [13:0]  tmr_d;
        logic [13:0]  gap_ms;
        logic [13:0]  long_ms;
        logic [5:1]   obj_q;
        logic         req;
        logic [2:0]   req_ofs;
        logic         req_val;
        logic         rx_hit;
        logic [2:0]   rx_ofs;
        logic [7:0]   deb_ms;
        logic [2:0]   deb_sel;

        assign deb_sel = (deb_sel_i[3*c +: 3] > mpd_pkg::DEB_MAX_SEL) ?
                         mpd_pkg::DEB_MAX_SEL : deb_sel_i[3*c +: 3];
        assign deb_ms  = mpd_pkg::DEB_TABLE_MS[8*deb_sel +: 8];

        contact_filter u_filt (
            .clk_i    (clk_i),
            .rst_i    (rst_i),
            .tick_i   (tick_q),
            .raw_i    (contact_i[c]),
            .deb_ms_i (deb_ms),
            .level_o  (filt_level)
        );

        // Manual operation bypasses the block entirely.
        assign src_level = manual_mode_i[c] ? manual_level_i[c] : filt_level;
        assign blocked   = block_q & block_en_i[c] & ~manual_mode_i[c];
        assign blocked_o[c] = blocked;
        // The held level differs from the source after unblock, so it is taken at once.
        assign edge_now  = ~blocked & (src_level != eff_q);
        assign pressed   = src_level ^ pol_open_i[c];
        assign press_edge = edge_now & pressed;
        assign rel_edge   = edge_now & ~pressed;
        assign max_cnt   = {1'b0, max_fold_i[2*c +: 2]} + 3'h1;
        assign gap_ms    = clamp_ms(gap_ms_i[14*c +: 14]);
        assign long_ms   = clamp_ms(long_ms_i[14*c +: 14]);

        assign rx_ofs = 3'(rx_obj_i - 7'(mpd_pkg::OBJ_BASE + c * mpd_pkg::OBJ_STEP));
        assign rx_hit = rx_valid_i
                      && rx_obj_i >= 7'(mpd_pkg::OBJ_BASE + c * mpd_pkg::OBJ_STEP)
                      && rx_obj_i <  7'(mpd_pkg::OBJ_BASE + c * mpd_pkg::OBJ_STEP
                                        + mpd_pkg::OBJ_STEP);

        always_comb begin
            st_d    = st_q;
            cnt_d   = cnt_q;
            tmr_d   = tmr_q;
            req     = 1'b0;
            req_ofs = mpd_pkg::OFS_FOLD1;
            req_val = 1'b0;
            if (tick_q && tmr_q != 14'h3fff) begin
                tmr_d = tmr_q + 14'h1;
            end
            case (st_q)
                S_IDLE: begin
                    if (press_edge) begin
                        st_d  = S_PRESS;
                        cnt_d = 3'h1;
                        tmr_d = 14'h0;
                        if (send_each_i[c]) begin
                            req     = 1'b1;
                            req_ofs = mpd_pkg::OFS_FOLD1;
                            req_val = sent_value(fold_sel_i[2*c +: 2], obj_q[1]);
                        end
                    end
                end
                S_PRESS: begin
                    if (blocked) begin
                        tmr_d = tmr_q;
                    end
                    if (rel_edge) begin
                        st_d  = S_GAP;
                        tmr_d = 14'h0;
                    end else if (long_en_i[c] && tmr_q >= long_ms) begin
                        st_d    = S_LONG;
                        cnt_d   = 3'h0;
                        req     = 1'b1;
                        req_ofs = mpd_pkg::OFS_LONG;
                        req_val = sent_value(long_sel_i[2*c +: 2], obj_q[5]);
                    end
                end
                S_GAP: begin
                    if (press_edge) begin
                        st_d  = S_PRESS;
                        tmr_d = 14'h0;
                        if (cnt_q < max_cnt) begin
                            cnt_d = cnt_q + 3'h1;
                            if (send_each_i[c]) begin
                                req     = 1'b1;
                                req_ofs = cnt_q + mpd_pkg::OFS_FOLD1;
                                req_val = sent_value(fold_sel_i[2*c +: 2], obj_q[cnt_q + 3'h1]);
                            end
                        end
                    end else if (tmr_q >= gap_ms) begin
                        st_d = S_IDLE;
                        if (!send_each_i[c]) begin
                            req     = 1'b1;
                            req_ofs = cnt_q;
                            req_val = sent_value(fold_sel_i[2*c +: 2], obj_q[cnt_q]);
                        end
                    end
                end
                S_LONG: begin
                    if (rel_edge) begin
                        st_d = S_IDLE;
                    end
                end
                default: begin
                    st_d = S_IDLE;
                end
            endcase
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                st_q  <= S_IDLE;
                cnt_q <= 3'h0;
                tmr_q <= 14'h0;
                eff_q <= 1'b0;
            end else begin
                st_q  <= st_d;
                cnt_q <= cnt_d;
                tmr_q <= tmr_d;
                if (edge_now) begin
                    eff_q <= src_level;
                end
            end
        end

        // Stored object values; a local send overrides a received write.
        always_ff @(posedge clk_i) begin
            if (rst_i || !block_en_i[c]) begin
                block_q <= mpd_pkg::BLOCK_RST_VAL;
            end else if (rx_hit && rx_ofs == mpd_pkg::OFS_BLOCK) begin
                block_q <= rx_val_i;
            end
        end

        for (genvar k = 1; k <= mpd_pkg::MAX_FOLD + 1; k++) begin : g_obj
            logic live;
            assign live = (k == mpd_pkg::MAX_FOLD + 1) ? long_en_i[c]
                        : (3'(k) <= max_cnt);
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    obj_q[k] <= mpd_pkg::OBJ_RST_VAL;
                end else if (req && req_ofs == 3'(k)) begin
                    obj_q[k] <= req_val;
                end else if (rx_hit && live && rx_ofs == 3'(k)) begin
                    obj_q[k] <= rx_val_i;
                end
            end
        end

        // A new request in the grant cycle stays pending.
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                pend_q[c]     <= 1'b0;
                pend_ofs_q[c] <= 3'h0;
                pend_val_q[c] <= 1'b0;
            end else if (req) begin
                pend_q[c]     <= 1'b1;
                pend_ofs_q[c] <= req_ofs;
                pend_val_q[c] <= req_val;
            end else if (grant[c]) begin
                pend_q[c]     <= 1'b0;
            end
        end
    end

endmodule : multi_press_detector
`default_nettype wire

// *** design/mpd_pkg.sv ***
/*
 * Shared constants for the multiple-press detector: object numbering,
 * sent-value encodings, timer defaults and the tick timebase.
 * Assumes a 100 MHz system clock and one-millisecond tick timing.
 */
// How it works
// - Presses beyond the configured maximum count leave the count at the maximum and send nothing.
// - Only count objects 1 up to the configured maximum are live.
// - Each count object sends on, off, or the inverse of its stored value.
// - With per-press sending, each actuation up to the maximum sends the object for the running count.
// - Without per-press sending, only the final count object is sent.
// - Gap timer restarts on each actuation; on expiry the sequence ends.
// - A long press inside a sequence discards short presses and sends long object.
// - Long object has its own sent value and exists only when enabled.
// - Input n owns object numbers 10n+10 to 10n+19.
// - Offsets: 0 block, 1..4 count objects, 5 long; all one bit.
// - Blocked input ignores changes and pauses long wait but still sends.
// - On unblock a changed input level is processed at once.
// - Manual operation ignores the block and keeps being processed.
// - An input edge acts at once, then edges are ignored for the debounce time.
// - A press lasting the long threshold is classed as long.
// - Polarity setting picks closing or opening as actuation.
package mpd_pkg;

    localparam int          NUM_INPUTS    = 8;
    localparam int          OBJ_BASE      = 10;
    localparam int          OBJ_STEP      = 10;
    localparam logic [2:0]  OFS_BLOCK     = 3'h0;
    localparam logic [2:0]  OFS_FOLD1     = 3'h1;
    localparam logic [2:0]  OFS_LONG      = 3'h5;
    localparam int          MAX_FOLD      = 4;

    // Sent-value selection codes.
    localparam logic [1:0]  SEND_ON       = 2'h0;
    localparam logic [1:0]  SEND_OFF      = 2'h1;
    localparam logic [1:0]  SEND_TOGGLE   = 2'h2;

    // Timer fields are milliseconds.
    localparam int          MS_W          = 14;
    localparam logic [13:0] GAP_DEF_MS    = 14'h01f4;
    localparam logic [13:0] LONG_DEF_MS   = 14'h0258;
    localparam logic [13:0] TIME_MIN_MS   = 14'h012c;
    localparam logic [13:0] TIME_MAX_MS   = 14'h2710;

    // Debounce choices 10/20/30/50/70/100/150 ms, index 0 first.
    localparam logic [55:0] DEB_TABLE_MS  = {8'h96, 8'h64, 8'h46, 8'h32, 8'h1e, 8'h14, 8'h0a};
    localparam logic [2:0]  DEB_MAX_SEL   = 3'h6;

    // Millisecond tick from the system clock.
    localparam int          CLK_FREQ_HZ   = 100_000_000;
    localparam int          TICK_MS       = 1;
    localparam int          TICK_CYCLES   = CLK_FREQ_HZ / 1000 * TICK_MS;

    // Reset values.
    localparam logic        OBJ_RST_VAL   = 1'b0;
    localparam logic        BLOCK_RST_VAL = 1'b0;

endpackage : mpd_pkg

// *** design/contact_filter.sv ***
/*
 * One input front end: two-flop synchroniser and edge debounce.
 * Assumes a one-cycle millisecond tick on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module contact_filter (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       tick_i,
    input  wire logic       raw_i,
    input  wire logic [7:0] deb_ms_i,
    output logic            level_o
);

    logic       sync1_q;
    logic       sync2_q;
    logic [7:0] deb_q;
    logic       accept;

    // A new level is taken at once; the hold window then masks bounce.
    assign accept = (deb_q == 8'h00) && (sync2_q != level_o);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= raw_i;
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_o <= 1'b0;
            deb_q   <= 8'h00;
        end else if (accept) begin
            level_o <= sync2_q;
            deb_q   <= deb_ms_i;
        end else if (tick_i && deb_q != 8'h00) begin
            deb_q   <= deb_q - 8'h01;
        end
    end

endmodule : contact_filter
`default_nettype wire

// *** bench/mpd_asserts.sv ***
/* Concurrent checks on the detector's telegram and block ports.
   Assumes it is bound to every instance of multi_press_detector. */
`timescale 1ns/1ps
`default_nettype none
module mpd_asserts #(
    parameter int N = 8
) (
    input wire logic           clk_i,
    input wire logic           rst_i,
    input wire logic [N-1:0]   manual_mode_i,
    input wire logic [N-1:0]   long_en_i,
    input wire logic [N-1:0]   block_en_i,
    input wire logic [2*N-1:0] max_fold_i,
    input wire logic [2*N-1:0] fold_sel_i,
    input wire logic           rx_valid_i,
    input wire logic [6:0]     rx_obj_i,
    input wire logic           rx_val_i,
    input wire logic           tx_valid_o,
    input wire logic           tx_ready_i,
    input wire logic [6:0]     tx_obj_o,
    input wire logic           tx_val_o,
    input wire logic [N-1:0]   blocked_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_stall;
        tx_valid_o && !tx_ready_i;
    endsequence
    sequence s_fold0;
        tx_valid_o && tx_obj_o inside {[7'h0b:7'h0e]};
    endsequence
    tx_hold_a: assert property (s_stall |=> tx_valid_o && $stable(tx_obj_o)
        && $stable(tx_val_o)) else $error("telegram changed before acceptance");
    obj_range_a: assert property (
        tx_valid_o |-> tx_obj_o >= 7'h0a && tx_obj_o <= 7'h59)
        else $error("object number outside input blocks");
    obj_offset_a: assert property (
        tx_valid_o |-> (tx_obj_o % 7'h0a) <= 7'h05) else $error("bad object offset");
    fold_cap_a: assert property (
        s_fold0 |-> (tx_obj_o - 7'h0b) <= {5'h00, max_fold_i[1:0]})
        else $error("fold object above maximum");
    fold_val_a: assert property (
        s_fold0 and fold_sel_i[1:0] != mpd_pkg::SEND_TOGGLE
        |-> tx_val_o == (fold_sel_i[1:0] == mpd_pkg::SEND_ON)) else $error("fold value wrong");
    long_gate_a: assert property (
        tx_valid_o && tx_obj_o == 7'h2d |-> long_en_i[3]) else $error("long object not enabled");
    block_man_a: assert property (
        (blocked_o & manual_mode_i) == {N{1'b0}}) else $error("manual input blocked");
    block_en_a: assert property (
        (blocked_o & ~block_en_i) == {N{1'b0}}) else $error("block without block object");
    block_write_a: assert property (
        rx_valid_i && rx_obj_i == 7'h32 && block_en_i[4] && !manual_mode_i[4]
        ##1 block_en_i[4] && !manual_mode_i[4] |-> blocked_o[4] == $past(rx_val_i))
        else $error("block write not applied");
endmodule : mpd_asserts
bind multi_press_detector mpd_asserts #(.N(N)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .manual_mode_i(manual_mode_i), .long_en_i(long_en_i), .block_en_i(block_en_i),
    .max_fold_i(max_fold_i), .fold_sel_i(fold_sel_i), .rx_valid_i(rx_valid_i),
    .rx_obj_i(rx_obj_i), .rx_val_i(rx_val_i), .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i), .tx_obj_o(tx_obj_o), .tx_val_o(tx_val_o), .blocked_o(blocked_o));
`default_nettype wire

// *** bench/tel_sink.sv ***
/* Telegram sink standing for the bus: accepts and logs telegrams.
   Assumes the detector holds a telegram until it is accepted. */
`timescale 1ns/1ps
`default_nettype none
module tel_sink (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       slow_i,
    input  wire logic       tx_valid_i,
    input  wire logic [6:0] tx_obj_i,
    input  wire logic       tx_val_i,
    output logic            tx_ready_o
);
    logic [7:0] log_q[$];
    logic [1:0] cnt_q;
    // When slow, ready is offered on one cycle in four.
    always @(posedge clk_i) begin
        cnt_q <= rst_i ? 2'h0 : cnt_q + 2'h1;
        tx_ready_o <= !rst_i && (!slow_i || cnt_q == 2'h3);
        if (!rst_i && tx_valid_i && tx_ready_o) begin
            log_q.push_back({tx_obj_i, tx_val_i});
        end
    end
endmodule : tel_sink
`default_nettype wire

// *** bench/multi_press_detector_tb_top.sv ***
/* Directed testbench for the multiple-press detector.
   Assumes a 1 ms tick of 10 clocks and the tel_sink bus model. */
`timescale 1ns/1ps
`default_nettype none
module multi_press_detector_tb_top;
    localparam int N  = 8;
    localparam int MS = 10;
    logic            clk_i, rst_i, rx_valid_i, rx_val_i, tx_ready_i, tx_valid_o, tx_val_o, slow;
    logic [N-1:0]    contact_i, manual_mode_i, manual_level_i, pol_open_i;
    logic [N-1:0]    send_each_i, long_en_i, block_en_i, blocked_o;
    logic [2*N-1:0]  max_fold_i, fold_sel_i, long_sel_i;
    logic [3*N-1:0]  deb_sel_i;
    logic [14*N-1:0] gap_ms_i, long_ms_i;
    logic [6:0]      rx_obj_i, tx_obj_o;
    int              mismatches, comparisons, cycles;
    multi_press_detector #(.N(N), .TICK_CYCLES(MS)) uut (.clk_i(clk_i), .rst_i(rst_i),
        .contact_i(contact_i), .manual_mode_i(manual_mode_i), .manual_level_i(manual_level_i),
        .pol_open_i(pol_open_i), .send_each_i(send_each_i), .long_en_i(long_en_i),
        .block_en_i(block_en_i), .max_fold_i(max_fold_i), .fold_sel_i(fold_sel_i),
        .long_sel_i(long_sel_i), .deb_sel_i(deb_sel_i), .gap_ms_i(gap_ms_i),
        .long_ms_i(long_ms_i), .rx_valid_i(rx_valid_i), .rx_obj_i(rx_obj_i),
        .rx_val_i(rx_val_i), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
        .tx_obj_o(tx_obj_o), .tx_val_o(tx_val_o), .blocked_o(blocked_o));
    tel_sink sink (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .tx_valid_i(tx_valid_o),
        .tx_obj_i(tx_obj_o), .tx_val_i(tx_val_o), .tx_ready_o(tx_ready_i));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cyc
    task automatic press(input int i, input int hold_ms);
        contact_i[i] = ~contact_i[i];
        cyc(hold_ms * MS);
        contact_i[i] = ~contact_i[i];
        cyc(20 * MS);
    endtask : press
    task automatic rx(input logic [6:0] o, input logic v);
        rx_valid_i = 1'b1;
        rx_obj_i = o;
        rx_val_i = v;
        cyc(1);
        rx_valid_i = 1'b0;
        cyc(1);
    endtask : rx
    task automatic exp_tel(input string name, input logic [6:0] o, input logic v);
        int n;
        logic [7:0] got;
        n = 0;
        got = 8'hff;
        while (sink.log_q.size() == 0 && n < 4000) begin
            cyc(1);
            n++;
        end
        if (sink.log_q.size() > 0) begin
            got = sink.log_q.pop_front();
        end
        check(name, got, {o, v});
    endtask : exp_tel
    task automatic exp_none(input string name);
        check(name, 8'(sink.log_q.size()), 8'h00);
    endtask : exp_none
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_each();
        send_each_i[0] = 1'b1;
        max_fold_i[1:0] = 2'h2;
        slow = 1'b1;
        repeat (4) press(0, 20);
        exp_tel("fold1", 7'h0b, 1'b1);
        exp_tel("fold2", 7'h0c, 1'b1);
        exp_tel("fold3", 7'h0d, 1'b1);
        cyc(3500);
        exp_none("beyond max");
        slow = 1'b0;
        $display("each-press test done");
    endtask : t_each
    task automatic t_final();
        fold_sel_i[3:2] = mpd_pkg::SEND_OFF;
        press(1, 20);
        press(1, 20);
        cyc(2500);
        exp_none("before gap");
        exp_tel("final fold", 7'h16, 1'b0);
        $display("final-count test done");
    endtask : t_final
    task automatic t_toggle();
        send_each_i[2] = 1'b1;
        fold_sel_i[5:4] = mpd_pkg::SEND_TOGGLE;
        press(2, 20);
        exp_tel("toggle first", 7'h1f, 1'b1);
        cyc(3500);
        press(2, 20);
        exp_tel("toggle back", 7'h1f, 1'b0);
        cyc(3500);
        rx(7'h1f, 1'b1);
        press(2, 20);
        exp_tel("toggle after write", 7'h1f, 1'b0);
        cyc(3500);
        $display("toggle test done");
    endtask : t_toggle
    task automatic t_long();
        long_en_i[3] = 1'b1;
        long_sel_i[7:6] = mpd_pkg::SEND_OFF;
        press(3, 20);
        press(3, 350);
        exp_tel("long object", 7'h2d, 1'b0);
        cyc(3500);
        exp_none("short discarded");
        $display("long test done");
    endtask : t_long
    task automatic t_block();
        block_en_i[4] = 1'b1;
        send_each_i[4] = 1'b1;
        rx(7'h32, 1'b1);
        check("blocked", {7'h00, blocked_o[4]}, 8'h01);
        press(4, 20);
        exp_none("blocked press");
        manual_mode_i[4] = 1'b1;
        cyc(2);
        check("manual unblocked", {7'h00, blocked_o[4]}, 8'h00);
        manual_level_i[4] = 1'b1;
        cyc(200);
        manual_level_i[4] = 1'b0;
        exp_tel("manual press", 7'h33, 1'b1);
        cyc(3500);
        manual_mode_i[4] = 1'b0;
        cyc(2);
        contact_i[4] = 1'b1;
        cyc(200);
        exp_none("held while blocked");
        rx(7'h32, 1'b0);
        exp_tel("unblock edge", 7'h33, 1'b1);
        contact_i[4] = 1'b0;
        cyc(3500);
        $display("block test done");
    endtask : t_block
    task automatic t_pol_deb();
        send_each_i[6:5] = 2'h3;
        contact_i[5] = 1'b0;
        cyc(100);
        check("open actuation", 8'(sink.log_q.size()), 8'h01);
        contact_i[5] = 1'b1;
        exp_tel("open object", 7'h3d, 1'b1);
        contact_i[6] = 1'b1;
        cyc(30);
        contact_i[6] = 1'b0;
        cyc(30);
        contact_i[6] = 1'b1;
        cyc(200);
        contact_i[6] = 1'b0;
        cyc(200);
        exp_tel("debounced press", 7'h47, 1'b1);
        exp_none("bounce ignored");
        $display("polarity and debounce test done");
    endtask : t_pol_deb
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 80000) begin
            mismatches++;
            final_report();
        end
    end
    initial begin
        {rst_i, slow, rx_valid_i, rx_val_i, rx_obj_i} = {1'b1, 10'h000};
        {manual_mode_i, manual_level_i, send_each_i, long_en_i, block_en_i} = '0;
        contact_i = 8'h20;
        pol_open_i = 8'h20;
        {max_fold_i, fold_sel_i, long_sel_i, deb_sel_i} = {16'hffff, 56'h0};
        gap_ms_i = {N{mpd_pkg::TIME_MIN_MS}};
        long_ms_i = {N{mpd_pkg::TIME_MIN_MS}};
        cyc(3);
        rst_i = 1'b0;
        cyc(2);
        t_each();
        t_final();
        t_toggle();
        t_long();
        t_block();
        t_pol_deb();
        final_report();
    end
endmodule : multi_press_detector_tb_top
`default_nettype wire
